// ===== verilog/exec_cfg.svh
// Constants for the OR, stack, rotate and branch execute block.
// Included by the execute module; holds definitions only.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// Opcodes
`define OP_OR_A_DIR 8'h45
`define OP_OR_A_IND 7'h23
`define OP_OR_A_IMM 8'h44
`define OP_OR_D_A 8'h42
`define OP_OR_D_IMM 8'h43
`define OP_OR_C_BIT 8'h72
`define OP_OR_C_NBIT 8'ha0
`define OP_POP 8'hd0
`define OP_PUSH 8'hc0
`define OP_SUB_EXIT 8'h22
`define OP_INT_EXIT 8'h32
`define OP_ROT_L 8'h23
`define OP_ROT_LC 8'h33
`define OP_ROT_R 8'h03
`define OP_ROT_RC 8'h13
`define OP_SET_C 8'hd3
`define OP_SET_BIT 8'hd2
`define OP_BRANCH 8'h80
// Memory spaces on the data port
`define SPACE_DIRECT 2'h0
`define SPACE_INDIRECT 2'h1
`define SPACE_BIT 2'h2
// Reset values and stack pointer address
`define ACC_RESET 8'h00
`define STACK_PTR_RESET 8'h07
`define PROG_CNT_RESET 16'h0000
`define STACK_PTR_ADDR 8'h81
`endif

// ===== verilog/exec_pkg.sv
// Types shared by the execute block and its surroundings.
// Assumes exec_cfg.svh for constant values.
package exec_pkg;
    // One request to internal RAM, SFR space or bit space
    typedef struct packed {
        logic rd;
        logic wr;
        logic latch;
        logic [1:0] space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_type;

    // Values of the two indirect pointer registers of the active bank
    typedef struct packed {
        logic [7:0] ptr1;
        logic [7:0] ptr0;
    } ind_ptr_type;

    typedef enum logic [2:0] {ST_OP, ST_B2, ST_B3, ST_RD, ST_RLO} exec_state_type;
endpackage

// ===== verilog/or_stack_exec.sv
// Execute block for byte OR, bit OR into carry, stack, returns, rotates, bit set, short jump.
// Assumes a byte fetch stream that restarts at PC_OUT after PC_LOAD, and a data port
// whose MEM_RDATA answers the read request shown in the same cycle.
// What this block does
// RULE1: OR into accumulator from direct, indirect or immediate; direct takes three cycles, the others two.
// RULE2: OR into direct byte from accumulator or immediate data, written back.
// RULE3: Bit OR into carry sets carry when bit is one, else keeps it.
// RULE4: Complemented bit OR uses inverted bit; source bit and other flags untouched.
// RULE5: Pop reads RAM at pointer, decrements pointer, stores byte to direct address.
// RULE6: Pop into the stack pointer: decrement first, then the popped byte wins.
// RULE7: Push increments pointer first, then stores direct byte at new pointer.
// RULE8: Subroutine exit pops high then low program counter byte, pointer minus two.
// RULE9: Interrupt exit returns likewise and re-arms the serviced priority level.
// RULE10: Interrupt exit restores nothing but program counter and stack pointer.
// RULE11: After interrupt exit one more instruction runs before a pending interrupt.
// RULE12: Rotate left wraps bit 7 into bit 0; carry unchanged.
// RULE13: Rotate left via carry: bit 7 into carry, old carry into bit 0.
// RULE14: Rotate right wraps bit 0 into bit 7; no flags change.
// RULE15: Rotate right via carry: bit 0 into carry, old carry into bit 7.
// RULE16: Bit set forces carry or a direct bit to one.
// RULE17: Short jump target is address plus two plus signed displacement.
// RULE18: Short jump is opcode then displacement byte, two bytes.
// RULE19: Byte OR forms change no flag.
// RULE20: Byte OR into a port reads the output latch, not the pins; OR into the accumulator reads the pins.
// RULE21: Stack pointer arithmetic wraps modulo 256, stack accessed indirectly.
`include "exec_cfg.svh"

module or_stack_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Instruction byte stream
    input wire logic FETCH_VALID,
    input wire logic [7:0] FETCH_BYTE,
    output logic FETCH_READY,
    // Program counter
    output logic [15:0] PC_OUT,
    output logic PC_LOAD,
    // Data port
    output mem_req_type MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    input wire ind_ptr_type IND_PTR,
    // Core state
    output logic [7:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic [7:0] SP_OUT,
    output logic INSTR_DONE,
    // Interrupt logic
    output logic IRQ_REARM,
    output logic IRQ_HOLD
);

    // Eight-bit stack pointer steps, wrapping modulo 256
    function automatic logic [7:0] sp_step(input logic [7:0] sp, input logic up);
        sp_step = up ? 8'(sp + 8'h01) : 8'(sp - 8'h01); // see RULE21
    endfunction

    exec_state_type state_ff, nxt_state;
    logic [7:0] op_ff, nxt_op;
    logic [7:0] arg_ff, nxt_arg;
    logic [7:0] imm_ff, nxt_imm;
    logic [7:0] acc_ff, nxt_acc;
    logic carry_ff, nxt_carry;
    logic [7:0] sp_ff, nxt_sp;
    logic [15:0] pc_ff, nxt_pc;
    logic load_ff, nxt_load;
    logic done_ff, nxt_done;
    logic rearm_ff, nxt_rearm;
    logic hold_ff, nxt_hold;
    mem_req_type req_ff, nxt_req;
    logic take;

    // Handshake toward the fetch stream
    assign FETCH_READY = (state_ff == ST_OP) || (state_ff == ST_B2) || (state_ff == ST_B3);
    assign take = FETCH_READY && FETCH_VALID;

    // Instruction sequencing and execution
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_arg = arg_ff;
        nxt_imm = imm_ff;
        nxt_acc = acc_ff;
        nxt_carry = carry_ff;
        nxt_sp = sp_ff;
        nxt_pc = pc_ff;
        nxt_load = 1'b0;
        nxt_done = 1'b0;
        nxt_rearm = 1'b0;
        nxt_hold = hold_ff;
        nxt_req = '0;
        unique case (state_ff)
            ST_OP: begin
                if (take) begin
                    nxt_op = FETCH_BYTE;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_done = 1'b1;
                    if (FETCH_BYTE[7:1] == `OP_OR_A_IND) begin
                        // Indirect operand through pointer register
                        nxt_req.rd = 1'b1; // see RULE1
                        nxt_req.space = `SPACE_INDIRECT;
                        nxt_req.addr = FETCH_BYTE[0] ? IND_PTR.ptr1 : IND_PTR.ptr0;
                        nxt_done = 1'b0;
                        nxt_state = ST_RD;
                    end else begin
                        case (FETCH_BYTE)
                            `OP_ROT_L: nxt_acc = {acc_ff[6:0], acc_ff[7]}; // see RULE12
                            `OP_ROT_LC: begin
                                nxt_acc = {acc_ff[6:0], carry_ff}; // see RULE13
                                nxt_carry = acc_ff[7];
                            end
                            `OP_ROT_R: nxt_acc = {acc_ff[0], acc_ff[7:1]}; // see RULE14
                            `OP_ROT_RC: begin
                                nxt_acc = {carry_ff, acc_ff[7:1]}; // see RULE15
                                nxt_carry = acc_ff[0];
                            end
                            `OP_SET_C: nxt_carry = 1'b1; // see RULE16
                            `OP_SUB_EXIT, `OP_INT_EXIT: begin
                                // High byte of return address first
                                nxt_req.rd = 1'b1; // see RULE8
                                nxt_req.space = `SPACE_INDIRECT;
                                nxt_req.addr = sp_ff;
                                nxt_done = 1'b0;
                                nxt_state = ST_RD;
                            end
                            `OP_OR_A_DIR, `OP_OR_A_IMM, `OP_OR_D_A, `OP_OR_D_IMM,
                            `OP_OR_C_BIT, `OP_OR_C_NBIT, `OP_POP, `OP_PUSH,
                            `OP_SET_BIT, `OP_BRANCH: begin
                                nxt_done = 1'b0;
                                nxt_state = ST_B2;
                            end
                            default: ;
                        endcase
                    end
                end
            end
            ST_B2: begin
                if (take) begin
                    nxt_arg = FETCH_BYTE;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_req.addr = FETCH_BYTE;
                    nxt_req.space = `SPACE_DIRECT;
                    nxt_state = ST_RD;
                    case (op_ff)
                        `OP_OR_A_IMM: begin
                            nxt_acc = acc_ff | FETCH_BYTE; // see RULE1
                            nxt_done = 1'b1;
                            nxt_state = ST_OP;
                        end
                        `OP_OR_D_IMM: nxt_state = ST_B3; // see RULE2
                        `OP_OR_D_A: begin
                            nxt_req.rd = 1'b1;
                            nxt_req.latch = 1'b1; // see RULE20
                        end
                        `OP_OR_C_BIT, `OP_OR_C_NBIT: begin
                            nxt_req.rd = 1'b1;
                            nxt_req.space = `SPACE_BIT;
                        end
                        `OP_POP: begin
                            nxt_req.rd = 1'b1; // see RULE5
                            nxt_req.space = `SPACE_INDIRECT;
                            nxt_req.addr = sp_ff;
                        end
                        `OP_SET_BIT: begin
                            nxt_req.wr = 1'b1; // see RULE16
                            nxt_req.space = `SPACE_BIT;
                            nxt_req.wdata = 8'h01;
                            nxt_done = 1'b1;
                            nxt_state = ST_OP;
                        end
                        `OP_BRANCH: begin
                            // Instruction address plus two plus signed displacement
                            nxt_pc = 16'(pc_ff + 16'h0001 + {{8{FETCH_BYTE[7]}}, FETCH_BYTE}); // see RULE17
                            nxt_load = 1'b1; // see RULE18
                            nxt_done = 1'b1;
                            nxt_state = ST_OP;
                        end
                        default: nxt_req.rd = 1'b1;
                    endcase
                end
            end
            ST_B3: begin
                if (take) begin
                    // Immediate mask, then read-modify-write of the direct byte
                    nxt_imm = FETCH_BYTE;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_req.rd = 1'b1;
                    nxt_req.latch = 1'b1; // see RULE20
                    nxt_req.space = `SPACE_DIRECT;
                    nxt_req.addr = arg_ff;
                    nxt_state = ST_RD;
                end
            end
            ST_RD: begin
                nxt_done = 1'b1;
                nxt_state = ST_OP;
                nxt_req.space = `SPACE_DIRECT;
                nxt_req.addr = arg_ff;
                case (op_ff)
                    `OP_OR_D_A: begin
                        nxt_req.wr = 1'b1; // see RULE2
                        nxt_req.wdata = MEM_RDATA | acc_ff; // see RULE19
                    end
                    `OP_OR_D_IMM: begin
                        nxt_req.wr = 1'b1; // see RULE2
                        nxt_req.wdata = MEM_RDATA | imm_ff; // see RULE19
                    end
                    `OP_OR_C_BIT: nxt_carry = carry_ff | MEM_RDATA[0]; // see RULE3
                    `OP_OR_C_NBIT: nxt_carry = carry_ff | ~MEM_RDATA[0]; // see RULE4
                    `OP_POP: begin
                        nxt_sp = sp_step(sp_ff, 1'b0); // see RULE5
                        if (arg_ff == `STACK_PTR_ADDR) begin
                            nxt_sp = MEM_RDATA; // see RULE6
                        end else begin
                            nxt_req.wr = 1'b1;
                            nxt_req.wdata = MEM_RDATA;
                        end
                    end
                    `OP_PUSH: begin
                        nxt_sp = sp_step(sp_ff, 1'b1); // see RULE7
                        nxt_req.wr = 1'b1;
                        nxt_req.space = `SPACE_INDIRECT;
                        nxt_req.addr = sp_step(sp_ff, 1'b1);
                        nxt_req.wdata = MEM_RDATA;
                    end
                    `OP_SUB_EXIT, `OP_INT_EXIT: begin
                        // Status word and other registers are left alone
                        nxt_pc = {MEM_RDATA, pc_ff[7:0]}; // see RULE10
                        nxt_sp = sp_step(sp_ff, 1'b0); // see RULE8
                        nxt_req.rd = 1'b1;
                        nxt_req.space = `SPACE_INDIRECT;
                        nxt_req.addr = sp_step(sp_ff, 1'b0);
                        nxt_done = 1'b0;
                        nxt_state = ST_RLO;
                    end
                    default: nxt_acc = acc_ff | MEM_RDATA; // see RULE1
                endcase
            end
            ST_RLO: begin
                nxt_pc = {pc_ff[15:8], MEM_RDATA}; // see RULE8
                nxt_sp = sp_step(sp_ff, 1'b0);
                nxt_load = 1'b1;
                nxt_done = 1'b1;
                nxt_state = ST_OP;
                if (op_ff == `OP_INT_EXIT) begin
                    nxt_rearm = 1'b1; // see RULE9
                end
            end
            default: nxt_state = ST_OP;
        endcase
        // Block vectoring until one instruction after the interrupt exit completes
        if (nxt_rearm) begin
            nxt_hold = 1'b1; // see RULE11
        end else if (done_ff && !rearm_ff) begin
            nxt_hold = 1'b0; // see RULE11
        end
    end

    // State registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= ST_OP;
            op_ff <= 8'h00;
            arg_ff <= 8'h00;
            imm_ff <= 8'h00;
            acc_ff <= `ACC_RESET;
            carry_ff <= 1'b0;
            sp_ff <= `STACK_PTR_RESET;
            pc_ff <= `PROG_CNT_RESET;
            load_ff <= 1'b0;
            done_ff <= 1'b0;
            rearm_ff <= 1'b0;
            hold_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            arg_ff <= nxt_arg;
            imm_ff <= nxt_imm;
            acc_ff <= nxt_acc;
            carry_ff <= nxt_carry;
            sp_ff <= nxt_sp;
            pc_ff <= nxt_pc;
            load_ff <= nxt_load;
            done_ff <= nxt_done;
            rearm_ff <= nxt_rearm;
            hold_ff <= nxt_hold;
            req_ff <= nxt_req;
        end
    end

    // Outputs straight from registers
    assign PC_OUT = pc_ff;
    assign PC_LOAD = load_ff;
    assign MEM_REQ = req_ff;
    assign ACC_OUT = acc_ff;
    assign CARRY_OUT = carry_ff;
    assign SP_OUT = sp_ff;
    assign INSTR_DONE = done_ff;
    assign IRQ_REARM = rearm_ff;
    assign IRQ_HOLD = hold_ff;

    // Checks
    a_rotate_left: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE12
        (state_ff == ST_OP && take && FETCH_BYTE == `OP_ROT_L) |=>
        acc_ff == {$past(acc_ff[6:0]), $past(acc_ff[7])} && $stable(carry_ff))
        else $error("rotate left result wrong");
    a_rotl_carry: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE13
        (state_ff == ST_OP && take && FETCH_BYTE == `OP_ROT_LC) |=>
        carry_ff == $past(acc_ff[7]) && acc_ff[0] == $past(carry_ff))
        else $error("rotate left via carry wrong");
    a_rotr_carry: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE15
        (state_ff == ST_OP && take && FETCH_BYTE == `OP_ROT_RC) |=>
        carry_ff == $past(acc_ff[0]) && acc_ff[7] == $past(carry_ff))
        else $error("rotate right via carry wrong");
    a_bit_or_carry: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE3
        (state_ff == ST_RD && op_ff == `OP_OR_C_BIT) |=>
        carry_ff == ($past(carry_ff) | $past(MEM_RDATA[0])))
        else $error("bit OR into carry wrong");
    a_push_order: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE7
        (state_ff == ST_RD && op_ff == `OP_PUSH) |=>
        MEM_REQ.wr && MEM_REQ.addr == sp_ff && sp_ff == 8'($past(sp_ff) + 8'h01))
        else $error("push pointer or write wrong");
    a_pop_self: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE6
        (state_ff == ST_RD && op_ff == `OP_POP && arg_ff == `STACK_PTR_ADDR) |=>
        sp_ff == $past(MEM_RDATA) && !MEM_REQ.wr)
        else $error("pop into stack pointer wrong");
    a_return_seq: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE8
        (state_ff == ST_RD && (op_ff == `OP_SUB_EXIT || op_ff == `OP_INT_EXIT)) |=>
        state_ff == ST_RLO ##1 PC_LOAD && sp_ff == 8'($past(sp_ff, 2) - 8'h02))
        else $error("return sequence wrong");
    a_exit_hold: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE11
        IRQ_REARM |-> IRQ_HOLD ##1 IRQ_HOLD)
        else $error("interrupt hold not raised");
    a_branch_target: assert property (@(posedge CLK) disable iff (!ARST_N) // see RULE17
        (state_ff == ST_B2 && take && op_ff == `OP_BRANCH) |=> PC_LOAD &&
        PC_OUT == 16'($past(pc_ff) + 16'h0001 + {{8{$past(FETCH_BYTE[7])}}, $past(FETCH_BYTE)}))
        else $error("short jump target wrong");

endmodule // or_stack_exec

// ===== verification/mem_model.sv
// Partner model: program byte source plus direct, indirect and bit data spaces.
// Assumes the bench preloads the arrays and moves stop_addr to pace the fetch stream.
module mem_model
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bench pacing
    input wire logic [15:0] stop_addr,
    input wire logic slow,
    // Fetch side
    input wire logic fetch_ready,
    input wire logic [15:0] pc_out,
    input wire logic pc_load,
    output logic fetch_valid,
    output logic [7:0] fetch_byte,
    // Data side
    input wire mem_req_type mem_req,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] prog [0:65535];
    logic [7:0] dir_mem [0:255];
    logic [7:0] iram [0:255];
    logic bit_mem [0:255];
    logic [15:0] fptr;
    logic [7:0] lfsr;
    logic [7:0] last_rd = 8'h00;
    logic [7:0] rd_val;

    // Known filler so an idle line never shows a stale byte
    initial begin
        for (int i = 0; i < 65536; i++)
            prog[i] = 8'h00;
    end

    // Bytes offered up to the stop address, never while the block restarts
    assign fetch_valid = (fptr != stop_addr) && !pc_load && !(slow && lfsr[0]);
    assign fetch_byte = fetch_valid ? prog[fptr] : ~prog[fptr];

    // Same-cycle read; port at 90h shows pins unless the latch is asked for
    always_comb begin
        case (mem_req.space)
            2'h0: rd_val = (mem_req.addr == 8'h90 && !mem_req.latch) ? ~dir_mem[8'h90]
                                                                     : dir_mem[mem_req.addr];
            2'h1: rd_val = iram[mem_req.addr];
            default: rd_val = {7'h00, bit_mem[mem_req.addr]};
        endcase
        mem_rdata = mem_req.rd ? rd_val : ~last_rd;
    end

    // Fetch pointer and stall pattern
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fptr <= 16'h0000;
            lfsr <= 8'h5b;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            if (pc_load)
                fptr <= pc_out;
            else if (fetch_valid && fetch_ready)
                fptr <= fptr + 16'h0001;
        end
    end

    // Writes land on the edge that ends the request cycle; bench preloads share the arrays
    always @(posedge clk) begin
        if (mem_req.rd)
            last_rd <= rd_val;
        if (mem_req.wr) begin
            case (mem_req.space)
                2'h0: dir_mem[mem_req.addr] <= mem_req.wdata;
                2'h1: iram[mem_req.addr] <= mem_req.wdata;
                default: bit_mem[mem_req.addr] <= mem_req.wdata[0];
            endcase
        end
    end
endmodule // mem_model

// ===== verification/or_stack_exec_tb.sv
// Self-checking bench for the OR, stack, rotate and short jump execute block.
// Assumes mem_model as program and data memory; expectations come from bench functions.
module or_stack_exec_tb
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic slow = 1'b0;
    logic [15:0] stop_addr = 16'h0000;
    ind_ptr_type ind_ptr = '0;
    logic fetch_valid, fetch_ready, pc_load, carry_out, instr_done, irq_rearm, irq_hold;
    logic [7:0] fetch_byte, mem_rdata, acc_out, sp_out;
    logic [15:0] pc_out, wp;
    mem_req_type mem_req;
    int n_mismatch = 0;
    int comparisons = 0;
    int n = 0;
    logic [7:0] ib [0:7];
    logic [7:0] rops [0:3] = '{8'h23, 8'h33, 8'h03, 8'h13};
    logic [7:0] rels [0:3] = '{8'h80, 8'h7f, 8'hfe, 8'h00};
    logic rearm_seen, hold_done, hold_after;
    logic [31:0] r, r2;
    logic [7:0] a, v, d, ea, ed, op;
    logic c, ec, eb;

    always #2 clk = ~clk;

    or_stack_exec i_or_stack_exec (.CLK(clk), .ARST_N(arst_n), .FETCH_VALID(fetch_valid),
        .FETCH_BYTE(fetch_byte), .FETCH_READY(fetch_ready), .PC_OUT(pc_out), .PC_LOAD(pc_load),
        .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .IND_PTR(ind_ptr), .ACC_OUT(acc_out),
        .CARRY_OUT(carry_out), .SP_OUT(sp_out), .INSTR_DONE(instr_done),
        .IRQ_REARM(irq_rearm), .IRQ_HOLD(irq_hold));

    mem_model i_mem_model (.clk(clk), .arst_n(arst_n), .stop_addr(stop_addr), .slow(slow),
        .fetch_ready(fetch_ready), .pc_out(pc_out), .pc_load(pc_load),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    // Accumulator and carry after a rotate
    function automatic logic [8:0] rot(input logic [7:0] o, input logic [7:0] x, input logic cy);
        case (o)
            8'h23: rot = {cy, x[6:0], x[7]};
            8'h33: rot = {x[7], x[6:0], cy};
            8'h03: rot = {cy, x[0], x[7:1]};
            default: rot = {x[0], cy, x[7:1]};
        endcase
    endfunction

    // Short jump target: address plus two plus signed displacement
    function automatic logic [15:0] br(input logic [15:0] at, input logic [7:0] rel);
        br = at + 16'h0002 + {{8{rel[7]}}, rel};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset(input logic s, input ind_ptr_type p);
        @(posedge clk);
        arst_n <= 1'b0;
        stop_addr <= 16'h0000;
        slow <= s;
        ind_ptr <= p;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        wp = 16'h0000;
        @(negedge clk);
    endtask

    // Append cnt bytes, high byte first
    task automatic put(input int cnt, input logic [23:0] b);
        for (int i = cnt - 1; i >= 0; i--) begin
            ib[n] = b[8*i +: 8];
            n++;
        end
    endtask

    // Place queued bytes, run nd instructions, fetch stops at nxt
    task automatic exec(input int nd, input logic [15:0] nxt);
        int guard;
        for (int i = 0; i < n; i++)
            i_mem_model.prog[wp + 16'(i)] = ib[i];
        rearm_seen = 1'b0;
        @(posedge clk);
        // A jump onto itself must first be fetched once, so stop past it for now
        stop_addr <= (nxt == wp) ? wp + 16'(n) : nxt;
        for (int k = 0; k < nd; k++) begin
            guard = 0;
            do begin
                @(negedge clk);
                guard++;
            end while (instr_done !== 1'b1 && guard < 64);
            chk(16'(instr_done), 16'h0001);
            rearm_seen |= irq_rearm;
            hold_done = irq_hold;
        end
        @(posedge clk);
        stop_addr <= nxt;
        @(negedge clk);
        hold_after = irq_hold;
        chk(pc_out, nxt);
        wp = nxt;
        n = 0;
    endtask

    task automatic go(input int nd);
        exec(nd, wp + 16'(n));
    endtask

    // Cut a hung run short
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h407fc00d));
        do_reset(1'b0, '0);
        chk({acc_out, sp_out}, 16'h0007);
        chk(pc_out, 16'h0000);
        // Every byte-OR, bit and rotate form on random data, queued back to back
        for (int it = 0; it < 44; it++) begin
            r = $urandom;
            r2 = $urandom;
            a = r[7:0];
            v = r[15:8];
            d = r[23] ? 8'h90 : {1'b0, r[22:16]};
            c = r[24];
            do_reset(r[25], r2[31:16]);
            i_mem_model.dir_mem[d] = v;
            i_mem_model.bit_mem[d] = v[0];
            i_mem_model.iram[r[26] ? r2[31:24] : r2[23:16]] = v;
            ea = a;
            ec = c;
            ed = v;
            eb = v[0];
            put(2, {8'h00, 8'h44, a});
            if (c)
                put(1, 24'h0000d3);
            case (it % 11)
                0: begin
                    put(2, {8'h00, 8'h45, d});
                    ea = a | ((d == 8'h90) ? ~v : v);
                end
                1: begin
                    put(1, {16'h0000, 7'h23, r[26]});
                    ea = a | v;
                end
                2: begin
                    put(2, {8'h00, 8'h42, d});
                    ed = v | a;
                end
                3: begin
                    put(3, {8'h43, d, r2[7:0]});
                    ed = v | r2[7:0];
                end
                8: begin
                    put(2, {8'h00, 8'h72, d});
                    ec = c | v[0];
                end
                9: begin
                    put(2, {8'h00, 8'ha0, d});
                    ec = c | ~v[0];
                end
                10: begin
                    put(2, {8'h00, 8'hd2, d});
                    eb = 1'b1;
                end
                default: begin
                    op = rops[(it % 11) - 4];
                    put(1, {16'h0000, op});
                    {ec, ea} = rot(op, a, c);
                end
            endcase
            go(c ? 3 : 2);
            chk(acc_out, ea);
            chk(carry_out, ec);
            chk(i_mem_model.dir_mem[d], ed);
            chk(i_mem_model.bit_mem[d], eb);
        end
        // Stack wrap, pop into the pointer, returns and short jumps
        do_reset(1'b1, '0);
        i_mem_model.iram[8'h07] = 8'hff;
        i_mem_model.dir_mem[8'h20] = 8'h5a;
        put(1, 24'h0000d3);
        put(2, 24'h0044c5);
        put(2, 24'h00d081);
        go(3);
        chk(sp_out, 8'hff);
        put(2, 24'h00c020);
        go(1);
        chk(sp_out, 8'h00);
        chk(i_mem_model.iram[8'h00], 8'h5a);
        put(2, 24'h00d030);
        go(1);
        chk(sp_out, 8'hff);
        chk(i_mem_model.dir_mem[8'h30], 8'h5a);
        i_mem_model.iram[8'hff] = 8'h01;
        i_mem_model.iram[8'hfe] = 8'h40;
        i_mem_model.iram[8'hfd] = 8'h02;
        i_mem_model.iram[8'hfc] = 8'h00;
        put(1, 24'h000022);
        exec(1, 16'h0140);
        chk(sp_out, 8'hfd);
        chk(16'(rearm_seen), 16'h0000);
        put(1, 24'h000032);
        exec(1, 16'h0200);
        chk(sp_out, 8'hfb);
        chk(16'(rearm_seen), 16'h0001);
        chk(16'(hold_after), 16'h0001);
        chk({7'h00, carry_out, acc_out}, 16'h01c5);
        put(1, 24'h000023);
        go(1);
        chk(16'(hold_done), 16'h0001);
        chk(16'(hold_after), 16'h0000);
        chk({7'h00, carry_out, acc_out}, 16'h018b);
        foreach (rels[j]) begin
            put(2, {8'h00, 8'h80, rels[j]});
            exec(1, br(wp, rels[j]));
        end
        wrap_up();
    end
endmodule // or_stack_exec_tb
